// file: pkg/gl_pkg.sv
package gl_pkg;

  // ---------------------------------------------------------------
  // clock division
  // ---------------------------------------------------------------
  localparam int DIV_2M_BIT = 1;   // divide by 4
  localparam int DIV_500K_BIT = 3; // divide by 16

  // ---------------------------------------------------------------
  // address map, 24-bit byte addresses
  // ---------------------------------------------------------------
  localparam logic [23:0] VEC_END = 24'h000008;
  localparam logic [23:0] SYS_BEG = 24'h000008;
  localparam logic [23:0] SYS_END = 24'h000800;
  localparam logic [23:0] RAM0_END = 24'h07FFFF;
  localparam logic [23:0] RAM1_BEG = 24'h080000;
  localparam logic [23:0] RAM1_END = 24'h0FFFFF;
  localparam logic [23:0] ROM0_BEG = 24'hFC0000;
  localparam logic [23:0] ROM0_END = 24'hFCFFFF;
  localparam logic [23:0] ROM0_BOOT_END = 24'hFC4000;
  localparam logic [23:0] ROM1_BEG = 24'hFD0000;
  localparam logic [23:0] ROM1_END = 24'hFDFFFF;
  localparam logic [23:0] ROM2_BEG = 24'hFE0000;
  localparam logic [23:0] ROM2_END = 24'hFEFFFF;
  localparam logic [7:0] IO_BANK = 8'hFF;
  localparam logic [7:0] PG_MEMCTL = 8'h80;
  localparam logic [7:0] PG_REGS = 8'h82;
  localparam logic [7:0] PG_DMA = 8'h86;
  localparam logic [7:0] PG_SND = 8'h88;
  localparam logic [7:0] PG_PIC = 8'hFA;
  localparam logic [7:0] PG_SER = 8'hFC;

  // ---------------------------------------------------------------
  // bus timing and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_TIMEOUT_CYC = 8'h40;
  localparam logic RST_HZ60 = 1'b0;

  // ---------------------------------------------------------------
  // video timing counts
  // ---------------------------------------------------------------
  localparam logic [6:0] H_LAST = 7'h3F;
  localparam logic [6:0] H_SYNC = 7'h06;
  localparam logic [6:0] H_VIS_BEG = 7'h0A;
  localparam logic [6:0] H_ACT_BEG = 7'h0E;
  localparam logic [6:0] H_ACT_END = 7'h36;
  localparam logic [6:0] H_VIS_END = 7'h3A;
  localparam logic [8:0] V_LAST_50 = 9'h138;
  localparam logic [8:0] V_LAST_60 = 9'h106;
  localparam logic [8:0] V_SYNC = 9'h003;
  localparam logic [8:0] V_VIS_BEG = 9'h014;
  localparam logic [8:0] V_ACT_BEG = 9'h028;
  localparam logic [8:0] V_ACT_END = 9'h0F0;
  localparam logic [8:0] V_VIS_END = 9'h104;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_ACT = 2'b01,
    B_DONE = 2'b11,
    B_FAULT = 2'b10
  } gl_bus_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic upper;
    logic lower;
    logic [2:0] cpu_function_code;
    logic valid_mem_addr_n;
    logic [23:0] addr;
    logic [15:0] wdata;
  } gl_cpu_t;

  typedef struct packed {
    logic ram;
    logic [2:0] rom;
    logic ser;
    logic pic;
    logic dma;
    logic snd;
    logic memctl;
    logic regs;
  } gl_sel_t;

  typedef struct packed {
    logic blank;
    logic active_line_flag;
    logic frame_sync_n;
    logic line_sync_n;
    logic frame_evt;
    logic line_evt;
  } gl_vid_t;

  // address decode, shared by the bus logic and its checks
  function automatic gl_sel_t gl_decode(input logic [23:0] a, input logic bank2,
                                        input logic boot16);
    gl_sel_t s;
    s = '0;
    if (a < VEC_END) begin
      s.rom[0] = 1'b1;
    end else if (a <= RAM0_END) begin
      s.ram = 1'b1;
    end else if (a >= RAM1_BEG && a <= RAM1_END) begin
      s.ram = bank2;
    end else if (a >= ROM0_BEG && a <= (boot16 ? ROM0_BOOT_END : ROM0_END)) begin
      s.rom[0] = 1'b1;
    end else if (a >= ROM1_BEG && a <= ROM1_END) begin
      s.rom[1] = 1'b1;
    end else if (a >= ROM2_BEG && a <= ROM2_END) begin
      s.rom[2] = 1'b1;
    end else if (a[23:16] == IO_BANK) begin
      s.memctl = (a[15:8] == PG_MEMCTL);
      s.regs = (a[15:8] == PG_REGS);
      s.dma = (a[15:8] == PG_DMA);
      s.snd = (a[15:8] == PG_SND);
      s.pic = (a[15:8] == PG_PIC);
      s.ser = (a[15:8] == PG_SER);
    end
    return s;
  endfunction

endpackage

// file: src/gl_vtiming.sv
`timescale 1ns/1ps
module gl_vtiming
  import gl_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic hz60_i,
  output gl_vid_t vid_o
);

  typedef struct packed {
    logic [6:0] h;
    logic [8:0] v;
    logic hz60;
    gl_vid_t o;
  } gl_vst_t;

  gl_vst_t s_r;
  gl_vst_t s_nxt;
  logic [8:0] v_last;

  // ---------------------------------------------------------------
  // raster counters and strobes
  // ---------------------------------------------------------------
  // rate is sampled only at frame end so a frame never mixes timings
  always_comb begin
    s_nxt = s_r;
    v_last = s_r.hz60 ? V_LAST_60 : V_LAST_50;
    s_nxt.h = s_r.h + 7'h01;
    if (s_r.h == H_LAST) begin
      s_nxt.h = 7'h00;
      s_nxt.v = s_r.v + 9'h001;
      if (s_r.v == v_last) begin
        s_nxt.v = 9'h000;
        s_nxt.hz60 = hz60_i;
      end
    end
    s_nxt.o.line_sync_n = !(s_nxt.h < H_SYNC);
    s_nxt.o.frame_sync_n = !(s_nxt.v < V_SYNC);
    s_nxt.o.active_line_flag = s_nxt.h >= H_ACT_BEG && s_nxt.h < H_ACT_END &&
                               s_nxt.v >= V_ACT_BEG && s_nxt.v < V_ACT_END;
    s_nxt.o.blank = !(s_nxt.h >= H_VIS_BEG && s_nxt.h < H_VIS_END &&
                      s_nxt.v >= V_VIS_BEG && s_nxt.v < V_VIS_END);
    s_nxt.o.line_evt = (s_nxt.h == 7'h00);
    s_nxt.o.frame_evt = (s_nxt.h == 7'h00) && (s_nxt.v == 9'h000);
  end

  // state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '{h: 7'h00, v: 9'h000, hz60: RST_HZ60,
               o: '{blank: 1'b1, active_line_flag: 1'b0, frame_sync_n: 1'b1,
                    line_sync_n: 1'b1, frame_evt: 1'b0, line_evt: 1'b0}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign vid_o = s_r.o;

endmodule

// file: src/gl_glue.sv
`timescale 1ns/1ps
module gl_glue
  import gl_pkg::*;
#(
  parameter logic [7:0] TIMEOUT_CYC = BUS_TIMEOUT_CYC
)(
  input wire logic clk_i,
  input wire logic nrst_i,
  input gl_cpu_t cpu_i,
  input wire logic transfer_ack_n_i,
  input wire logic periph_irq_n_i,
  input wire logic dma_req_i,
  input wire logic dma_byte_done_i,
  input wire logic ram_bank2_i,
  input wire logic boot_rom_small_i,
  output logic clk_2m_o,
  output logic clk_500k_o,
  output logic blank_o,
  output logic active_line_flag_o,
  output logic frame_sync_n_o,
  output logic line_sync_n_o,
  output logic [1:0] cpu_priority_lines_o,
  output logic int_ack_strobe_o,
  output gl_sel_t sel_o,
  output logic ram_upper_en_o,
  output logic ram_lower_en_o,
  output logic bus_fault_o,
  output logic own_ack_o,
  output logic [15:0] rdata_o,
  output logic cpu_bus_grant_o,
  output logic dma_grant_o,
  output logic mem_dma_strobe_o
);

  typedef struct packed {
    logic [3:0] div;
    logic clk2m;
    logic clk500k;
    logic strap_done;
    logic bank2;
    logic boot16;
    logic hz60;
    gl_bus_t bst;
    logic [7:0] to_cnt;
    logic frame_pend;
    logic line_pend;
    logic [1:0] prio;
    logic int_ack_strobe;
    gl_sel_t sel;
    logic upper;
    logic lower;
    logic fault;
    logic own_ack;
    logic [15:0] rdata;
    logic cpu_own;
    logic dma_grant;
    logic dma_strobe;
  } gl_st_t;

  gl_st_t s_r;
  gl_st_t s_nxt;
  gl_vid_t vid;
  gl_sel_t dsel;
  logic start;
  logic int_ack_strobe_cyc;
  logic [2:0] lvl;
  logic sys_acc;
  logic illegal;
  logic clr_frame;
  logic clr_line;

  // ---------------------------------------------------------------
  // video timing
  // ---------------------------------------------------------------
  gl_vtiming u_vtiming (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .hz60_i(s_r.hz60),
    .vid_o(vid)
  );

  // ---------------------------------------------------------------
  // cycle classification
  // ---------------------------------------------------------------
  // a cycle is taken only while the processor owns the bus
  assign start = cpu_i.valid && s_r.cpu_own && (s_r.bst == B_IDLE);
  assign int_ack_strobe_cyc = (&cpu_i.cpu_function_code) && !cpu_i.valid_mem_addr_n;
  assign lvl = cpu_i.addr[3:1];
  assign dsel = gl_decode(cpu_i.addr, s_r.bank2, s_r.boot16);
  assign sys_acc = cpu_i.addr >= SYS_BEG && cpu_i.addr < SYS_END;
  // word-only pages reject a write with one strobe missing
  assign illegal = cpu_i.wr && ((|dsel.rom) ||
                   ((dsel.regs || dsel.dma) && !(cpu_i.upper && cpu_i.lower)) ||
                   (!cpu_i.cpu_function_code[2] && sys_acc));

  // interrupt acknowledge of our own levels clears the pending flag
  assign clr_frame = start && int_ack_strobe_cyc && lvl == 3'h2;
  assign clr_line = start && int_ack_strobe_cyc && lvl == 3'h3;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // free-running divider; outputs taken from counter bits
    s_nxt.div = s_r.div + 4'h1;
    s_nxt.clk2m = s_nxt.div[DIV_2M_BIT];
    s_nxt.clk500k = s_nxt.div[DIV_500K_BIT];

    // straps caught once, just after reset release
    if (!s_r.strap_done) begin
      s_nxt.strap_done = 1'b1;
      s_nxt.bank2 = ram_bank2_i;
      s_nxt.boot16 = boot_rom_small_i;
    end

    // pending flags: a new event beats a same-cycle clear
    s_nxt.frame_pend = (s_r.frame_pend && !clr_frame) || vid.frame_evt;
    s_nxt.line_pend = (s_r.line_pend && !clr_line) || vid.line_evt;

    // priority encode, highest pending only
    if (s_nxt.line_pend) begin
      s_nxt.prio = 2'h3;
    end else if (s_nxt.frame_pend) begin
      s_nxt.prio = 2'h2;
    end else if (!periph_irq_n_i) begin
      s_nxt.prio = 2'h1;
    end else begin
      s_nxt.prio = 2'h0;
    end

    // bus cycle sequencer
    unique case (s_r.bst)
      B_IDLE: begin
        if (start) begin
          s_nxt.to_cnt = 8'h00;
          if (int_ack_strobe_cyc) begin
            s_nxt.bst = B_ACT;
            s_nxt.int_ack_strobe = (lvl == 3'h1);
            s_nxt.own_ack = (lvl == 3'h2) || (lvl == 3'h3);
          end else if (illegal) begin
            s_nxt.bst = B_FAULT;
            s_nxt.fault = 1'b1;
          end else begin
            s_nxt.bst = B_ACT;
            s_nxt.sel = dsel;
            s_nxt.upper = dsel.ram && cpu_i.upper;
            s_nxt.lower = dsel.ram && cpu_i.lower;
            s_nxt.own_ack = dsel.regs;
            s_nxt.rdata = {15'h0000, s_r.hz60 && dsel.regs};
            if (dsel.regs && cpu_i.wr) begin
              s_nxt.hz60 = cpu_i.wdata[0];
            end
          end
        end
      end
      B_ACT: begin
        s_nxt.to_cnt = s_r.to_cnt + 8'h01;
        if (!cpu_i.valid) begin
          s_nxt.bst = B_IDLE;
          s_nxt.sel = '0;
          s_nxt.upper = 1'b0;
          s_nxt.lower = 1'b0;
          s_nxt.int_ack_strobe = 1'b0;
          s_nxt.own_ack = 1'b0;
          s_nxt.rdata = 16'h0000;
        end else if (!transfer_ack_n_i || s_r.own_ack) begin
          s_nxt.bst = B_DONE;
        end else if (s_r.to_cnt == TIMEOUT_CYC - 8'h01) begin
          // silent device: drop its select and flag the processor
          s_nxt.bst = B_FAULT;
          s_nxt.fault = 1'b1;
          s_nxt.sel = '0;
          s_nxt.upper = 1'b0;
          s_nxt.lower = 1'b0;
          s_nxt.int_ack_strobe = 1'b0;
        end
      end
      B_DONE: begin
        if (!cpu_i.valid) begin
          s_nxt.bst = B_IDLE;
          s_nxt.sel = '0;
          s_nxt.upper = 1'b0;
          s_nxt.lower = 1'b0;
          s_nxt.int_ack_strobe = 1'b0;
          s_nxt.own_ack = 1'b0;
          s_nxt.rdata = 16'h0000;
        end
      end
      B_FAULT: begin
        if (!cpu_i.valid) begin
          s_nxt.bst = B_IDLE;
          s_nxt.fault = 1'b0;
        end
      end
    endcase

    // break-before-make hand-over so the two masters never overlap
    if (s_r.cpu_own && dma_req_i && s_r.bst == B_IDLE && !cpu_i.valid) begin
      s_nxt.cpu_own = 1'b0;
    end else if (!s_r.cpu_own && !s_r.dma_grant) begin
      s_nxt.dma_grant = dma_req_i;
      s_nxt.cpu_own = !dma_req_i;
    end else if (s_r.dma_grant && !dma_req_i) begin
      s_nxt.dma_grant = 1'b0;
    end

    // one strobe to the memory controller per byte taken
    s_nxt.dma_strobe = s_r.dma_grant && dma_byte_done_i;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_r <= '0;
      s_r.hz60 <= RST_HZ60;
      s_r.cpu_own <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs, all registered: the video ones from the u_vtiming state register, the rest from this one
  assign clk_2m_o = s_r.clk2m;
  assign clk_500k_o = s_r.clk500k;
  assign blank_o = vid.blank;
  assign active_line_flag_o = vid.active_line_flag;
  assign frame_sync_n_o = vid.frame_sync_n;
  assign line_sync_n_o = vid.line_sync_n;
  assign cpu_priority_lines_o = s_r.prio;
  assign int_ack_strobe_o = s_r.int_ack_strobe;
  assign sel_o = s_r.sel;
  assign ram_upper_en_o = s_r.upper;
  assign ram_lower_en_o = s_r.lower;
  assign bus_fault_o = s_r.fault;
  assign own_ack_o = s_r.own_ack;
  assign rdata_o = s_r.rdata;
  assign cpu_bus_grant_o = s_r.cpu_own;
  assign dma_grant_o = s_r.dma_grant;
  assign mem_dma_strobe_o = s_r.dma_strobe;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_div_2m_period: assert property (
    $rose(clk_2m_o) |-> ##4 $rose(clk_2m_o))
    else $error("2 MHz divider period wrong");

  a_div_500k_period: assert property (
    $rose(clk_500k_o) |-> ##16 $rose(clk_500k_o))
    else $error("500 kHz divider period wrong");

  a_active_not_blank: assert property (
    active_line_flag_o |-> !blank_o)
    else $error("active line shown while blanked");

  a_rate_setting_write: assert property (
    start && dsel.regs && cpu_i.wr && !illegal |=> ##1 s_r.hz60 == $past(cpu_i.wdata[0], 2))
    else $error("frame rate setting not written");

  a_line_prio_top: assert property (
    s_r.line_pend |-> cpu_priority_lines_o == 2'h3)
    else $error("line level not presented on top");

  a_frame_prio_mid: assert property (
    s_r.frame_pend && !s_r.line_pend |-> cpu_priority_lines_o == 2'h2)
    else $error("frame level wrong");

  a_int_ack_strobe_strobe_out: assert property (
    start && int_ack_strobe_cyc && lvl == 3'h1 |=> int_ack_strobe_o && !bus_fault_o)
    else $error("acknowledge strobe missing");

  a_rom_write_fault: assert property (
    start && !int_ack_strobe_cyc && cpu_i.wr && (|dsel.rom) |=> bus_fault_o && sel_o == '0)
    else $error("ROM write not faulted");

  a_user_sys_fault: assert property (
    start && !int_ack_strobe_cyc && cpu_i.wr && !cpu_i.cpu_function_code[2] && sys_acc
    |=> bus_fault_o)
    else $error("user write to system memory not faulted");

  a_ack_timeout: assert property (
    s_r.bst == B_ACT && cpu_i.valid && transfer_ack_n_i && !s_r.own_ack &&
    s_r.to_cnt == TIMEOUT_CYC - 8'h01 |=> bus_fault_o)
    else $error("missing acknowledge not faulted");

  a_vector_from_rom: assert property (
    start && !int_ack_strobe_cyc && !cpu_i.wr && cpu_i.addr < VEC_END |=> sel_o.rom[0] && !sel_o.ram)
    else $error("reset vectors not from ROM");

  a_bank2_absent: assert property (
    start && !int_ack_strobe_cyc && !s_r.bank2 && cpu_i.addr >= RAM1_BEG && cpu_i.addr <= RAM1_END
    |=> !sel_o.ram)
    else $error("absent bank enabled");

  a_masters_apart: assert property (
    !(cpu_bus_grant_o && dma_grant_o))
    else $error("both masters own the bus");

  a_dma_strobe_out: assert property (
    dma_grant_o && dma_byte_done_i |=> mem_dma_strobe_o)
    else $error("memory strobe missing after DMA byte");

  c_dma_grant: cover property ($rose(dma_grant_o));
  c_bus_fault: cover property ($rose(bus_fault_o));
  c_int_ack_strobe: cover property ($rose(int_ack_strobe_o));
  c_rate_60: cover property ($rose(s_r.hz60));

endmodule

// file: dv/gl_far_model.sv
`timescale 1ns/1ps
module gl_far_model
  import gl_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input gl_sel_t sel_i,
  input wire logic int_ack_strobe_i,
  input wire logic mute_i,
  input wire logic irq_i,
  output logic transfer_ack_n_o,
  output logic periph_irq_n_o
);
  int wait_r;

  // devices answer after 0..2 cycles; a muted device never answers
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r <= 0;
      transfer_ack_n_o <= 1'b1;
    end else if ((|sel_i[9:1] || int_ack_strobe_i) && !mute_i) begin
      if (wait_r == 0) begin
        transfer_ack_n_o <= 1'b0;
      end else begin
        wait_r <= wait_r - 1;
      end
    end else begin
      wait_r <= $urandom_range(2);
      transfer_ack_n_o <= 1'b1; // pulled up once released
    end
  end

  // request line stays low for as long as the source pends
  assign periph_irq_n_o = !irq_i;
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench
  import gl_pkg::*;
;
  logic clk_i = 0, nrst_i = 0, dma_req = 0, dma_done = 0, bank2 = 1, boot = 0;
  logic mute = 0, irq = 0, ack_n, irq_n, c2m, c500k, blank, act, fs_n, ls_n, int_ack_strobe;
  logic ue, le, fault, oack, cg, dg, mstb;
  logic s_fault, s_oack, s_int_ack_strobe, s_ack, s_ue, s_le;
  logic [1:0] prio;
  logic [15:0] rdata, s_rd;
  gl_sel_t sel, s_sel;
  gl_cpu_t cpu = '0;
  int err_count = 0, samples_checked = 0, act_seen = 0;
  logic rate_exp = RST_HZ60;

  always #50 clk_i = ~clk_i;

  gl_glue #(.TIMEOUT_CYC(8'h04)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .cpu_i(cpu),
    .transfer_ack_n_i(ack_n), .periph_irq_n_i(irq_n), .dma_req_i(dma_req),
    .dma_byte_done_i(dma_done), .ram_bank2_i(bank2), .boot_rom_small_i(boot),
    .clk_2m_o(c2m), .clk_500k_o(c500k), .blank_o(blank), .active_line_flag_o(act),
    .frame_sync_n_o(fs_n), .line_sync_n_o(ls_n), .cpu_priority_lines_o(prio),
    .int_ack_strobe_o(int_ack_strobe), .sel_o(sel), .ram_upper_en_o(ue), .ram_lower_en_o(le),
    .bus_fault_o(fault), .own_ack_o(oack), .rdata_o(rdata), .cpu_bus_grant_o(cg),
    .dma_grant_o(dg), .mem_dma_strobe_o(mstb));

  gl_far_model i_far (.clk_i(clk_i), .nrst_i(nrst_i), .sel_i(sel), .int_ack_strobe_i(int_ack_strobe),
    .mute_i(mute), .irq_i(irq), .transfer_ack_n_o(ack_n), .periph_irq_n_o(irq_n));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("mismatches %0d of %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // straps are sampled on the first edge after release
  task automatic do_reset(input logic b2, input logic bt);
    nrst_i = 0;
    bank2 = b2;
    boot = bt;
    repeat (10) @(posedge clk_i);
    rate_exp = RST_HZ60;
    check("rst", {cg, blank, fs_n, ls_n, dg, fault, oack, int_ack_strobe, mstb, prio,
      sel, rdata, c2m, c500k, act, ue, le}, {4'hF, 38'h0});
    #10 nrst_i = 1;
    repeat (2) @(posedge clk_i);
    #10;
  endtask

  // op packs write, upper, lower, function code and address
  task automatic bus(input logic [29:0] op, input logic [15:0] wd);
    cpu = '{1'b1, op[29], op[28], op[27], op[26:24], op[26:24] != 3'h7, op[23:0], wd};
    for (int n = 0; n < 12; n++) begin
      @(posedge clk_i);
      #10;
      if (fault || oack || !ack_n) break;
    end
    // hold the request over the edge at which the answer is taken
    @(posedge clk_i);
    #10;
    {s_sel, s_fault, s_oack, s_int_ack_strobe, s_ack, s_ue, s_le, s_rd} =
      {sel, fault, oack, int_ack_strobe, !ack_n, ue, le, rdata};
    cpu.valid = 0;
    repeat (2) @(posedge clk_i);
    #10;
  endtask

  function automatic gl_sel_t ref_sel(input int a, input bit b2, input bit bt);
    gl_sel_t s;
    int p;
    s = '0;
    p = (a >> 8) & 'hFF;
    if (a < 8) s.rom[0] = 1;
    else if (a < 'h80000) s.ram = 1;
    else if (a < 'h100000) s.ram = b2;
    else if (a >= 'hFC0000 && a <= (bt ? 'hFC4000 : 'hFCFFFF)) s.rom[0] = 1;
    else if (a >= 'hFD0000 && a < 'hFE0000) s.rom[1] = 1;
    else if (a >= 'hFE0000 && a < 'hFF0000) s.rom[2] = 1;
    else if (a >= 'hFF0000) begin
      s.memctl = p == 'h80;
      s.regs = p == 'h82;
      s.dma = p == 'h86;
      s.snd = p == 'h88;
      s.pic = p == 'hFA;
      s.ser = p == 'hFC;
    end
    return s;
  endfunction

  // illegal writes are refused, silent places time out
  task automatic run(input logic [29:0] op);
    gl_sel_t e;
    logic f;
    e = ref_sel(op[23:0], bank2, boot);
    f = op[29] && (|e.rom || (op[28] ^ op[27]) && (e.regs || e.dma) ||
      !op[26] && op[23:0] >= 24'h000008 && op[23:0] < 24'h000800);
    bus(op, 16'h0000);
    check("sel", s_sel, f ? '0 : e);
    check("fault", s_fault, f || e == '0);
    check("lanes", {s_ue, s_le}, e.ram && !f ? op[28:27] : 2'b00);
    check("rdata", s_rd, e.regs && !f ? {15'h0000, rate_exp} : 16'h0000);
    check("acks", {s_oack, s_int_ack_strobe}, {e.regs && !f, 1'b0});
  endtask

  task automatic per(input int s, input logic [31:0] exp, input string nm);
    int n;
    logic p;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      do begin
        p = s == 0 ? ls_n : s == 1 ? fs_n : s == 2 ? c2m : c500k;
        @(posedge clk_i);
        #10;
        n++;
      end while (!(p && !(s == 0 ? ls_n : s == 1 ? fs_n : s == 2 ? c2m : c500k)) && n < 50000);
      if (k == 0) n = 0;
    end
    check(nm, n, exp);
  endtask

  // per-cycle watch on ownership and display area
  always @(posedge clk_i) begin
    #10;
    if (nrst_i) begin
      if ((cg & dg) !== 1'b0) check("grants", 1, 0);
      if ((act & blank) !== 1'b0) check("act_blank", 1, 0);
      if ((~fs_n & ~blank) !== 1'b0) check("sync_blank", 1, 0);
      act_seen += int'(act === 1'b1);
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  logic [29:0] ops[] = '{30'h1D000000, 30'h1D000006, 30'h1D000008, 30'h1D07FFFE,
    30'h1D080000, 30'h1D0FFFFE, 30'h1D100000, 30'h1DFC0000, 30'h1DFC4000, 30'h1DFC4002,
    30'h1DFCFFFE, 30'h1DFD1234, 30'h1DFEFFFE, 30'h1DFF8000, 30'h1DFF8200, 30'h1DFF8600,
    30'h1DFF8800, 30'h1DFFFA00, 30'h1DFFFC00, 30'h1DFF8400, 30'h3DFC0010, 30'h35FF8200,
    30'h2DFF8600, 30'h39000100, 30'h390007FE, 30'h39000800, 30'h39000008, 30'h3D000100,
    30'h35FF8800};

  initial begin
    void'($urandom(59663));
    do_reset(1'b1, 1'b0);
    per(2, 4, "div2m");
    per(3, 16, "div500k");
    per(0, 64, "line");
    per(1, 313 * 64, "frame50");
    bus(30'h1DFF8200, 16'h0000);
    check("rate", s_rd[0], 0);
    bus(30'h3DFF8200, 16'h0001);
    rate_exp = 1'b1;
    bus(30'h1DFF8200, 16'h0000);
    check("rate", {s_oack, s_rd[0]}, 2'b11);
    per(1, 263 * 64, "frame60");
    check("active", act_seen > 0, 1);
    // a fresh line event realigns, leaving room for three acks
    bus(30'h1F000006, 16'h0000);
    for (int n = 0; n < 70 && prio !== 2'h3; n++) begin
      @(posedge clk_i);
      #10;
    end
    check("prio", prio, 3);
    bus(30'h1F000006, 16'h0000);
    check("prio", prio, 2);
    irq = 1;
    bus(30'h1F000004, 16'h0000);
    check("prio", prio, 1);
    bus(30'h1F000002, 16'h0000);
    check("int_ack_strobe", {s_int_ack_strobe, s_ack}, 2'b11);
    irq = 0;
    repeat (2) @(posedge clk_i);
    #10;
    check("prio", prio, 0);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) do_reset(1'b0, 1'b1);
      foreach (ops[i]) run(ops[i]);
      repeat (4) run({1'b0, 2'($urandom_range(1, 3)), 3'h5,
        24'($urandom_range(24'h000800, 24'h07FFFF)) & 24'hFFFFFE});
    end
    mute = 1;
    bus(30'h1D001000, 16'h0000);
    check("mute", s_fault, 1);
    mute = 0;
    dma_req = 1;
    for (int n = 0; n < 6 && dg !== 1'b1; n++) begin
      @(posedge clk_i);
      #10;
    end
    check("dma_own", {dg, cg}, 2'b10);
    cpu = '{1'b1, 1'b0, 1'b1, 1'b1, 3'h5, 1'b1, 24'h001000, 16'h0000};
    repeat (4) @(posedge clk_i);
    #10;
    check("held", {sel, fault}, 0);
    cpu.valid = 0;
    dma_done = 1;
    @(posedge clk_i);
    #10;
    dma_done = 0;
    check("strobe", mstb, 1);
    @(posedge clk_i);
    #10;
    check("strobe", mstb, 0);
    dma_req = 0;
    for (int n = 0; n < 6 && cg !== 1'b1; n++) begin
      @(posedge clk_i);
      #10;
    end
    check("cpu_own", {dg, cg}, 2'b01);
    give_verdict();
  end

  // the tests need about 80k cycles; this cuts a hang short below 100k
  initial begin
    repeat (95000) @(posedge clk_i);
    err_count++;
    give_verdict();
  end
endmodule
